// File: csp_asserts.sv
// Protocol checker on the serial link wires between the two ends
`default_nettype none
module csp_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Link wires
  input wire logic serial_clk,
  input wire logic output_frame_sync,
  input wire logic serial_out_line,
  input wire logic input_frame_sync,
  input wire logic serial_in_line
);
  // ==========
  // Cycles since each sync rose
  logic       ofs_q_ff;  // Output sync one cycle ago
  logic       ifs_q_ff;  // Input sync one cycle ago
  logic [8:0] og_ff;     // Output sync gap
  logic [8:0] ig_ff;     // Input sync gap
  logic [8:0] nxt_og;
  logic [8:0] nxt_ig;
  // Restart on a rise; saturate so an idle link never wraps
  always_comb begin
    nxt_og = (output_frame_sync & ~ofs_q_ff) ? 9'h000 : og_ff + {8'h00, ~&og_ff};
    nxt_ig = (input_frame_sync & ~ifs_q_ff) ? 9'h000 : ig_ff + {8'h00, ~&ig_ff};
  end
  // Reset to full gap so the first sync is legal
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ofs_q_ff <= 1'b0;
      ifs_q_ff <= 1'b0;
      og_ff    <= 9'h1ff;
      ig_ff    <= 9'h1ff;
    end else begin
      ofs_q_ff <= output_frame_sync;
      ifs_q_ff <= input_frame_sync;
      og_ff    <= nxt_og;
      ig_ff    <= nxt_ig;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_sclk_high_half: assert property ($rose(serial_clk) |=> serial_clk [*7] ##1 !serial_clk)
    else $error("bit clock high phase wrong");
  a_sclk_low_half: assert property ($fell(serial_clk) |=> !serial_clk [*7] ##1 serial_clk)
    else $error("bit clock low phase wrong");
  a_ofs_one_period: assert property ($rose(output_frame_sync) |=> $stable(output_frame_sync) [*8] ##8 $fell(output_frame_sync))
    else $error("output sync width wrong");
  a_ifs_one_period: assert property ($rose(input_frame_sync) |-> ##15 input_frame_sync ##1 !input_frame_sync)
    else $error("input sync width wrong");
  a_ofs_on_rise: assert property ($changed(output_frame_sync) |-> $rose(serial_clk))
    else $error("output sync moved off the clock rise");
  a_sdo_on_rise: assert property ($changed(serial_out_line) |-> $rose(serial_clk))
    else $error("output data moved off the clock rise");
  a_sdi_low_stable: assert property ($fell(serial_clk) |=> $stable({serial_in_line, input_frame_sync}) [*7])
    else $error("input wires moved while clock low");
  a_ofs_word_gap: assert property ((output_frame_sync && !ofs_q_ff) |-> og_ff >= 9'h0ff)
    else $error("output syncs closer than one word");
  a_ifs_word_gap: assert property ((input_frame_sync && !ifs_q_ff) |-> ig_ff >= 9'h0ff)
    else $error("input syncs closer than one word");
  // Main scenarios reached
  c_out_word: cover property ($rose(output_frame_sync));
  c_in_word: cover property ($rose(input_frame_sync));
  c_back_to_back: cover property (input_frame_sync && !ifs_q_ff && ig_ff == 9'h0ff);
endmodule
`default_nettype wire

// File: csp_device.sv
// Codec end of the serial cascade port
//
// Operation
// R1 - Frame sync precedes each 16-bit word
// R2 - Device generates the serial bit clock
// R3 - Indirect wiring: host makes input sync
// R4 - Direct wiring: output sync frames input too
// R5 - Host preloads first word before reset release
// R6 - Up to eight units, addressing in packets
// R7 - Units times 16 times rate within clock
// R8 - Sample interval is M divided clock cycles
// R9 - Host sends N words per interval
// R10 - Sample delivered within sixteen bit clocks
// R11 - Count input syncs, load converter on match
// R12 - Host programs cascade count as units minus one
// R13 - Cascade count resets to zero
// R14 - Four rates, constant modulator sampling rate
// R15 - Master divider scales rate, resets to one
// R16 - Widened accumulator avoids overflow at 8 kHz
// R17 - Shift MSB first after frame sync
// R18 - Select bits choose program, data, mixed
// R19 - Address zero accepts, else decrement and pass
// R20 - Slowest rate until second register written
// R21 - Mixed mode flag bit, 15-bit data
`include "csp_map.svh"
`default_nettype none
module csp_device (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // Serial link toward the host
  csp_link_if.dev            lnk,
  // Wiring style and modulator stream
  input  wire logic          direct_wiring,
  input  wire logic          mod_bit,
  // Converter and status side
  output logic [15:0]        dac_word,
  output logic               dac_load,
  output logic [15:0]        adc_word,
  output logic               sample_pulse,
  output csp_pkg::csp_mode_t mode,
  output logic [2:0]         cascade_count
);
  localparam logic [3:0] HALF     = 4'(`CSP_SCLK_HALF_CYC);
  localparam logic [3:0] BIT_LAST = 4'(2 * `CSP_SCLK_HALF_CYC - 1);
  localparam logic [4:0] WBITS    = 5'(`CSP_WORD_BITS);
  // Ones count of one interval to a 16-bit sample
  function automatic logic [15:0] scale(input logic [8:0] a, input logic [1:0] r);
    logic [24:0] w;
    w = {16'h0, a} << (4'hb - {2'b0, r});
    scale = (w[24:16] != 9'h0) ? 16'hffff : w[15:0];
  endfunction
  // ==========
  // Bit clock divider and input synchronisers
  logic [3:0] div_ff, nxt_div;       // Position inside one bit period
  logic       sclk_ff, nxt_sclk;     // Bit clock driven out
  logic [1:0] s1_ff, nxt_s1;         // First sync stage {sync, data}
  logic [1:0] s2_ff, nxt_s2;         // Second sync stage
  logic [1:0] s3_ff, nxt_s3;         // Third sync stage
  logic [1:0] filt_ff, nxt_filt;     // Accepted level once stages agree
  logic       bit_end;               // Last sys_clk cycle of a bit period
  assign bit_end = (div_ff == BIT_LAST);
  // Bit clock high in the first half of a period
  always_comb begin
    nxt_div  = bit_end ? 4'h0 : div_ff + 4'h1;
    nxt_sclk = (nxt_div < HALF);  // see R2
    nxt_s1   = {lnk.input_frame_sync, lnk.serial_in_line};
    nxt_s2   = s1_ff;
    nxt_s3   = s2_ff;
    nxt_filt = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & filt_ff);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff  <= 4'h0;
      sclk_ff <= 1'b1;
      s1_ff   <= 2'h0;
      s2_ff   <= 2'h0;
      s3_ff   <= 2'h0;
      filt_ff <= 2'h0;
    end else begin
      div_ff  <= nxt_div;
      sclk_ff <= nxt_sclk;
      s1_ff   <= nxt_s1;
      s2_ff   <= nxt_s2;
      s3_ff   <= nxt_s3;
      filt_ff <= nxt_filt;
    end
  end
  // ==========
  // Divided master clock, sample interval and decimation
  logic [2:0]  mdiv_ff;              // Master divider setting minus one
  logic [1:0]  rate_ff;              // Programmed interval select
  logic        rate_set_ff;          // Second config register written
  logic        mm_ff;                // Mixed mode bit
  logic [2:0]  mcnt_ff, nxt_mcnt;    // Master divider counter
  logic [2:0]  modc_ff, nxt_modc;    // Modulator tick counter
  logic [10:0] ivl_ff, nxt_ivl;      // Position inside the sample interval
  logic [8:0]  acc_ff, nxt_acc;      // Ones count, sized for the longest interval
  logic [15:0] adc_ff, nxt_adc;      // Latest sample
  logic        smp_ff, nxt_smp;      // Sample event pulse
  logic [1:0]  rate_eff;             // Interval select in force
  logic        dm_tick;              // One divided master clock cycle
  logic        sample_ev;            // Converter sampling event
  logic [8:0]  acc_in;               // Count including this tick
  logic [15:0] raw;                  // Scaled sample
  assign rate_eff  = rate_set_ff ? rate_ff : `CSP_RATE_DFLT;  // see R20
  assign dm_tick   = (mcnt_ff >= mdiv_ff);  // see R15
  assign sample_ev = dm_tick && (ivl_ff >= 11'((`CSP_M_BASE << rate_eff) - 1));  // see R8

  // Modulator runs at one eighth of the divided clock whatever the rate
  always_comb begin
    nxt_mcnt = dm_tick ? 3'h0 : mcnt_ff + 3'h1;
    nxt_modc = dm_tick ? modc_ff + 3'h1 : modc_ff;  // see R14
    nxt_ivl  = dm_tick ? (sample_ev ? 11'h0 : ivl_ff + 11'h1) : ivl_ff;
    acc_in   = acc_ff + {8'h0, dm_tick && (modc_ff == `CSP_MOD_LAST) && mod_bit};
    raw      = scale(acc_in, rate_eff);  // see R16
    nxt_acc  = sample_ev ? 9'h0 : acc_in;
    nxt_smp  = sample_ev;
    nxt_adc  = adc_ff;
    if (sample_ev) begin
      nxt_adc = mm_ff ? {1'b0, raw[15:1]} : raw;  // see R21
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mcnt_ff <= 3'h0;
      modc_ff <= 3'h0;
      ivl_ff  <= 11'h0;
      acc_ff  <= 9'h0;
      adc_ff  <= 16'h0;
      smp_ff  <= 1'b0;
    end else begin
      mcnt_ff <= nxt_mcnt;
      modc_ff <= nxt_modc;
      ivl_ff  <= nxt_ivl;
      acc_ff  <= nxt_acc;
      adc_ff  <= nxt_adc;
      smp_ff  <= nxt_smp;
    end
  end
  // ==========
  // Word engine: receive, configuration, transmit
  logic        dps_ff, nxt_dps;      // Data/program select
  logic        nxt_mm;
  logic [2:0]  dc_ff, nxt_dc;        // Cascade count field
  logic [1:0]  nxt_rate;
  logic        nxt_rate_set;
  logic [2:0]  nxt_mdiv;
  csp_pkg::csp_mode_t mode_ff, nxt_mode;
  logic [4:0]  icnt_ff, nxt_icnt;    // Input bits still to come
  logic [15:0] ish_ff, nxt_ish;      // Serial input register
  logic [2:0]  fsc_ff, nxt_fsc;      // Input frames since sample event
  logic [15:0] dac_ff, nxt_dac;      // Converter register
  logic        dld_ff, nxt_dld;      // Converter load pulse
  logic [15:0] pass_ff, nxt_pass;    // Word to forward down the cascade
  logic        ppend_ff, nxt_ppend;
  logic        apend_ff, nxt_apend;  // Sample waiting to go out
  logic [4:0]  ocnt_ff, nxt_ocnt;    // Output bits still to drive
  logic [15:0] osh_ff, nxt_osh;
  logic        ofs_ff, nxt_ofs;
  logic        sdo_ff, nxt_sdo;
  logic [15:0] word;                 // Word as completed this period
  logic        ifs_eff;              // Input sync in force

  assign word    = {ish_ff[14:0], filt_ff[0]};
  assign ifs_eff = direct_wiring ? ofs_ff : filt_ff[1];  // see R4 R3

  // All link decisions are taken at the end of a bit period
  always_comb begin
    nxt_dps = dps_ff;  nxt_mm = mm_ff;  nxt_dc = dc_ff;
    nxt_rate = rate_ff;  nxt_rate_set = rate_set_ff;  nxt_mdiv = mdiv_ff;
    nxt_icnt = icnt_ff;  nxt_ish = ish_ff;  nxt_fsc = sample_ev ? 3'h0 : fsc_ff;
    nxt_dac = dac_ff;  nxt_dld = 1'b0;  nxt_pass = pass_ff;  nxt_ppend = ppend_ff;
    nxt_apend = apend_ff | sample_ev;
    nxt_ocnt = ocnt_ff;  nxt_osh = osh_ff;  nxt_ofs = ofs_ff;  nxt_sdo = sdo_ff;
    if (bit_end) begin
      // Transmit: a new word's sync overlaps the last bit of the old one
      nxt_sdo = (ocnt_ff != 5'h0) ? osh_ff[15] : 1'b0;  // see R17
      nxt_ofs = 1'b0;
      if ((ocnt_ff <= 5'h1) && (apend_ff || ppend_ff)) begin
        nxt_ofs  = 1'b1;  // see R1 R10
        nxt_ocnt = WBITS;
        if (apend_ff) begin
          nxt_osh   = adc_ff;
          nxt_apend = sample_ev;
        end else begin
          nxt_osh   = pass_ff;
          nxt_ppend = 1'b0;
        end
      end else if (ocnt_ff != 5'h0) begin
        nxt_osh  = {osh_ff[14:0], 1'b0};
        nxt_ocnt = ocnt_ff - 5'h1;
      end
      // Receive: shift in, then act on the completed word
      if (icnt_ff != 5'h0) begin
        nxt_ish  = word;  // see R17
        nxt_icnt = icnt_ff - 5'h1;
      end
      if (icnt_ff == 5'h1) begin
        if (!dps_ff || (mm_ff && word[`CSP_W_FLAG])) begin
          if (word[`CSP_ADDR_HI:`CSP_ADDR_LO] == 3'h0) begin
            case (word[`CSP_REG_HI:`CSP_REG_LO])  // see R19
              `CSP_REG_CFG_A: begin
                nxt_dps = word[`CSP_A_DPS];  // see R18
                nxt_mm  = word[`CSP_A_MM];
                nxt_dc  = word[`CSP_A_DC_HI:`CSP_A_DC_LO];
              end
              `CSP_REG_CFG_B: begin
                nxt_rate     = word[1:0];
                nxt_rate_set = 1'b1;  // see R20
              end
              `CSP_REG_DIV: nxt_mdiv = word[2:0];
              default: nxt_mdiv = mdiv_ff;  // Other registers live elsewhere
            endcase
          end else begin
            // Not ours: pass on, address one lower
            nxt_pass  = {word[15], word[14:12] - 3'h1, word[11:0]};  // see R19 R6
            nxt_ppend = 1'b1;
          end
        end else begin
          if (fsc_ff == dc_ff) begin
            nxt_dac = mm_ff ? {word[14:0], 1'b0} : word;  // see R11 R21
            nxt_dld = 1'b1;
          end
          nxt_fsc = nxt_fsc + 3'h1;  // see R11
        end
      end
      if (ifs_eff) begin
        nxt_icnt = WBITS;  // see R1
      end
    end
    // Plain data mode locks the registers until the next reset
    if (!nxt_dps) begin
      nxt_mode = csp_pkg::CSP_PROGRAM;
    end else if (nxt_mm) begin
      nxt_mode = csp_pkg::CSP_MIXED;  // see R18
    end else begin
      nxt_mode = csp_pkg::CSP_DATA;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dps_ff <= 1'b0;  mm_ff <= 1'b0;  dc_ff <= `CSP_DC_RESET;  // see R13
      rate_ff <= 2'h0;  rate_set_ff <= 1'b0;  mdiv_ff <= `CSP_DIV_RESET;  // see R15
      mode_ff <= csp_pkg::CSP_PROGRAM;
      icnt_ff <= 5'h0;  ish_ff <= 16'h0;  fsc_ff <= 3'h0;
      dac_ff <= 16'h0;  dld_ff <= 1'b0;  pass_ff <= 16'h0;  ppend_ff <= 1'b0;
      apend_ff <= 1'b0;  ocnt_ff <= 5'h0;  osh_ff <= 16'h0;
      ofs_ff <= 1'b0;  sdo_ff <= 1'b0;
    end else begin
      dps_ff <= nxt_dps;  mm_ff <= nxt_mm;  dc_ff <= nxt_dc;
      rate_ff <= nxt_rate;  rate_set_ff <= nxt_rate_set;  mdiv_ff <= nxt_mdiv;
      mode_ff <= nxt_mode;
      icnt_ff <= nxt_icnt;  ish_ff <= nxt_ish;  fsc_ff <= nxt_fsc;
      dac_ff <= nxt_dac;  dld_ff <= nxt_dld;  pass_ff <= nxt_pass;  ppend_ff <= nxt_ppend;
      apend_ff <= nxt_apend;  ocnt_ff <= nxt_ocnt;  osh_ff <= nxt_osh;
      ofs_ff <= nxt_ofs;  sdo_ff <= nxt_sdo;
    end
  end

  // ==========
  // Outputs, all straight from flip-flops
  assign lnk.serial_clk        = sclk_ff;
  assign lnk.output_frame_sync = ofs_ff;
  assign lnk.serial_out_line   = sdo_ff;
  assign dac_word              = dac_ff;
  assign dac_load              = dld_ff;
  assign adc_word              = adc_ff;
  assign sample_pulse          = smp_ff;
  assign mode                  = mode_ff;
  assign cascade_count         = dc_ff;
endmodule
`default_nettype wire

// File: csp_host.sv
// Host end of the serial cascade port
`include "csp_map.svh"
`default_nettype none
module csp_host (
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rstn,
  // Serial link toward the device
  csp_link_if.host    lnk,
  // Wiring style
  input  wire logic   direct_wiring,
  // Words to send
  input  wire logic [15:0] tx_word,
  input  wire logic   tx_valid,
  output logic        tx_ready,
  // Words received
  output logic [15:0] rx_word,
  output logic        rx_valid
);
  localparam logic [4:0] WBITS = 5'(`CSP_WORD_BITS);

  // ==========
  // Pin synchronisers {clock, sync, data}
  logic [2:0] s1_ff, s2_ff, s3_ff, filt_ff;
  logic [2:0] nxt_filt;
  logic       prev_ff;                // Bit clock level last cycle
  logic       rise, fall;

  assign rise = filt_ff[2] & ~prev_ff;
  assign fall = ~filt_ff[2] & prev_ff;

  // A change counts once the second and third stages agree
  always_comb begin
    nxt_filt = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & filt_ff);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // Clock idles high in reset, so no false rise follows release
      s1_ff <= 3'h4;  s2_ff <= 3'h4;  s3_ff <= 3'h4;  filt_ff <= 3'h4;  prev_ff <= 1'b1;
    end else begin
      s1_ff   <= {lnk.serial_clk, lnk.output_frame_sync, lnk.serial_out_line};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= nxt_filt;
      prev_ff <= filt_ff[2];
    end
  end

  // ==========
  // Transmit and receive engines
  logic [15:0] buf_ff, nxt_buf;       // Holding register
  logic        full_ff, nxt_full;
  logic        rdy_ff, nxt_rdy;
  logic        arm_ff, nxt_arm;       // Device sync seen in direct wiring
  logic [4:0]  tcnt_ff, nxt_tcnt;
  logic [15:0] tsh_ff, nxt_tsh;
  logic        ifs_ff, nxt_ifs;
  logic        sdi_ff, nxt_sdi;
  logic [4:0]  rcnt_ff, nxt_rcnt;
  logic [15:0] rsh_ff, nxt_rsh;
  logic [15:0] rxw_ff, nxt_rxw;
  logic        rxv_ff, nxt_rxv;
  logic [15:0] dw;                    // Word sent in direct wiring

  assign dw = full_ff ? buf_ff : 16'h0;

  // Outputs move on the clock rise, inputs are sampled on its fall
  always_comb begin
    nxt_buf = buf_ff;  nxt_full = full_ff;  nxt_arm = arm_ff;
    nxt_tcnt = tcnt_ff;  nxt_tsh = tsh_ff;  nxt_ifs = ifs_ff;  nxt_sdi = sdi_ff;
    nxt_rcnt = rcnt_ff;  nxt_rsh = rsh_ff;  nxt_rxw = rxw_ff;  nxt_rxv = 1'b0;
    if (rise) begin
      nxt_ifs = 1'b0;
      if (direct_wiring && arm_ff) begin
        nxt_sdi  = dw[15];  // see R4 R5
        nxt_tsh  = {dw[14:0], 1'b0};
        nxt_tcnt = WBITS - 5'h1;
        nxt_full = 1'b0;
        nxt_arm  = 1'b0;
      end else begin
        nxt_sdi = (tcnt_ff != 5'h0) ? tsh_ff[15] : 1'b0;  // see R17
        if (!direct_wiring && full_ff && (tcnt_ff <= 5'h1)) begin
          // Own sync, back to back words allowed; see R3 R1 R9
          nxt_ifs  = 1'b1;
          nxt_tsh  = buf_ff;
          nxt_tcnt = WBITS;
          nxt_full = 1'b0;
        end else if (tcnt_ff != 5'h0) begin
          nxt_tsh  = {tsh_ff[14:0], 1'b0};
          nxt_tcnt = tcnt_ff - 5'h1;
        end
      end
    end
    if (fall) begin
      if (rcnt_ff != 5'h0) begin
        nxt_rsh  = {rsh_ff[14:0], filt_ff[0]};  // see R17
        nxt_rcnt = rcnt_ff - 5'h1;
      end
      if (rcnt_ff == 5'h1) begin
        nxt_rxw = {rsh_ff[14:0], filt_ff[0]};
        nxt_rxv = 1'b1;
      end
      if (filt_ff[1]) begin
        nxt_rcnt = WBITS;  // see R1
        nxt_arm  = direct_wiring;  // see R4
      end
    end
    if (tx_valid && rdy_ff) begin
      nxt_buf  = tx_word;
      nxt_full = 1'b1;
    end
    nxt_rdy = ~nxt_full;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      buf_ff <= 16'h0;  full_ff <= 1'b0;  rdy_ff <= 1'b1;  arm_ff <= 1'b0;
      tcnt_ff <= 5'h0;  tsh_ff <= 16'h0;  ifs_ff <= 1'b0;  sdi_ff <= 1'b0;
      rcnt_ff <= 5'h0;  rsh_ff <= 16'h0;  rxw_ff <= 16'h0;  rxv_ff <= 1'b0;
    end else begin
      buf_ff <= nxt_buf;  full_ff <= nxt_full;  rdy_ff <= nxt_rdy;  arm_ff <= nxt_arm;
      tcnt_ff <= nxt_tcnt;  tsh_ff <= nxt_tsh;  ifs_ff <= nxt_ifs;  sdi_ff <= nxt_sdi;
      rcnt_ff <= nxt_rcnt;  rsh_ff <= nxt_rsh;  rxw_ff <= nxt_rxw;  rxv_ff <= nxt_rxv;
    end
  end

  // ==========
  // Outputs, all straight from flip-flops
  assign lnk.input_frame_sync = ifs_ff;
  assign lnk.serial_in_line   = sdi_ff;
  assign tx_ready             = rdy_ff;
  assign rx_word              = rxw_ff;
  assign rx_valid             = rxv_ff;
endmodule
`default_nettype wire

// File: csp_link_if.sv
// Serial link wires between the codec device and its host
`default_nettype none
interface csp_link_if;
  logic serial_clk;         // Bit clock, made by the device
  logic output_frame_sync;  // Device to host frame sync
  logic serial_out_line;    // Device to host data
  logic input_frame_sync;   // Host to device frame sync
  logic serial_in_line;     // Host to device data
  modport dev  (output serial_clk, output output_frame_sync, output serial_out_line,
                input input_frame_sync, input serial_in_line);
  modport host (input serial_clk, input output_frame_sync, input serial_out_line,
                output input_frame_sync, output serial_in_line);
endinterface
`default_nettype wire

// File: csp_map.svh
// Timing counts, word fields and reset values of the serial port
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH
// ==========
// Timing
`define CSP_SYS_MHZ        125
`define CSP_SCLK_HALF_NS   64
`define CSP_SCLK_HALF_CYC  ((`CSP_SCLK_HALF_NS * `CSP_SYS_MHZ) / 1000)
`define CSP_WORD_BITS      16
`define CSP_M_BASE         256
`define CSP_MOD_LAST       3'h7
// ==========
// Control word fields
`define CSP_W_FLAG         15
`define CSP_ADDR_HI        14
`define CSP_ADDR_LO        12
`define CSP_REG_HI         11
`define CSP_REG_LO         8
`define CSP_REG_CFG_A      4'h0
`define CSP_REG_CFG_B      4'h1
`define CSP_REG_DIV        4'h2
`define CSP_A_DPS          0
`define CSP_A_MM           1
`define CSP_A_DC_LO        2
`define CSP_A_DC_HI        4
// ==========
// Reset values
`define CSP_DC_RESET       3'h0
`define CSP_DIV_RESET      3'h0
`define CSP_RATE_DFLT      2'h3
`endif

// File: csp_pkg.sv
// Types of the codec serial cascade port; the host end uses none of them
`default_nettype none
package csp_pkg;
  // Word moved over the link
  typedef logic [15:0] csp_word_t;
  // Operating mode of the device
  typedef enum logic [1:0] {
    CSP_PROGRAM,
    CSP_DATA,
    CSP_MIXED
  } csp_mode_t;
endpackage
`default_nettype wire

// File: tb_top.sv
// Bench joining both link ends
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Design signals
  logic               sys_clk;
  logic               rstn;
  logic               host_rstn;  // Host end, released first
  logic               direct_wiring;
  logic               mod_bit;
  logic [15:0]        tx_word;
  logic               tx_valid;
  logic               tx_ready;
  logic [15:0]        rx_word;
  logic               rx_valid;
  logic [15:0]        dac_word;
  logic               dac_load;
  logic               sample_pulse;
  csp_pkg::csp_mode_t mode;
  logic [2:0]         cascade_count;
  // Bench state
  int                 failures;
  int                 compares;
  int                 seed;
  int                 loads;      // Converter loads seen
  int                 ibit;       // Input bit index, -1 when idle
  int                 obit;       // Output bit index, -1 when idle
  logic [15:0]        ish;        // Input word being rebuilt
  logic [15:0]        osh;        // Output word being rebuilt
  logic [15:0]        last_dac;   // Word of the last load
  logic [15:0]        pass_exp;   // Word the device should pass on
  logic               seen_pass;
  logic               mixed_chk;  // Output top bit is checked
  logic [15:0]        sent_q[$];  // Words the host was given
  logic [15:0]        out_q[$];   // Words seen leaving the device
  logic [15:0]        w[8];
  csp_link_if lnk ();
  // ==========
  // Both ends and the checker
  csp_device csp_device_i (.sys_clk(sys_clk), .rstn(rstn), .lnk(lnk), .direct_wiring(direct_wiring),
    .mod_bit(mod_bit), .dac_word(dac_word), .dac_load(dac_load), .adc_word(),
    .sample_pulse(sample_pulse), .mode(mode), .cascade_count(cascade_count));
  csp_host csp_host_i (.sys_clk(sys_clk), .rstn(host_rstn), .lnk(lnk), .direct_wiring(direct_wiring),
    .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid));
  csp_asserts csp_asserts_i (.sys_clk(sys_clk), .rstn(rstn), .serial_clk(lnk.serial_clk),
    .output_frame_sync(lnk.output_frame_sync), .serial_out_line(lnk.serial_out_line),
    .input_frame_sync(lnk.input_frame_sync), .serial_in_line(lnk.serial_in_line));
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Random modulator stream
  always @(posedge sys_clk) begin
    #1 mod_bit = 1'($random(seed));
  end
  // ==========
  // Helpers
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: word %h, model %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: count %0d, model %0d", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [15:0] cw(input logic f, input logic [2:0] a, input logic [3:0] r, input logic [7:0] d);
    return {f, a, r, d};
  endfunction
  // Cycles up to the next sample pulse
  task automatic wait_sp(output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (sample_pulse !== 1'b1 && n < 9000);
  endtask
  // Hand one word to the host
  task automatic send(input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    while (tx_ready !== 1'b1 && n < 9000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    tx_word = wd;
    tx_valid = 1'b1;
    sent_q.push_back(wd);
    @(posedge sys_clk);
    #1 tx_valid = 1'b0;
  endtask
  // Reset; direct wiring loads the host first
  task automatic do_reset(input logic dw, input logic [15:0] pre);
    rstn = 1'b0;
    host_rstn = 1'b0;
    direct_wiring = dw;
    sent_q.delete();
    out_q.delete();
    ibit = -1;
    obit = -1;
    mixed_chk = 1'b0;
    @(posedge sys_clk);
    #1 host_rstn = 1'b1;
    if (dw) send(pre);
    repeat (3) @(posedge sys_clk);
    #1 rstn = 1'b1;
  endtask
  // ==========
  // Wire monitors, at the bit clock fall
  always @(negedge lnk.serial_clk) begin
    if (ibit >= 0) begin
      ish = {ish[14:0], lnk.serial_in_line};
      ibit++;
    end
    if (ibit == 16) begin
      chk16(ish, sent_q.size() > 0 ? sent_q.pop_front() : 16'hxxxx);
      ibit = -1;
    end
    if (lnk.input_frame_sync === 1'b1 && !direct_wiring) ibit = 0;
    if (obit >= 0) begin
      osh = {osh[14:0], lnk.serial_out_line};
      obit++;
    end
    if (obit == 16) begin
      out_q.push_back(osh);
      seen_pass = seen_pass | (osh === pass_exp);
      obit = -1;
    end
    if (lnk.output_frame_sync === 1'b1) obit = 0;
  end
  // Host words against the wire; loads
  always @(negedge sys_clk) begin
    if (rx_valid === 1'b1) begin
      chk16(rx_word, out_q.size() > 0 ? out_q.pop_front() : 16'hxxxx);
      if (mixed_chk) chk16({rx_word[15], 15'h0000}, 16'h0000);
    end
    if (dac_load === 1'b1) begin
      loads++;
      last_dac = dac_word;
    end
  end
  // Watchdog, about 98k cycles
  initial begin
    #784000;
    failures++;
    $display("unexpected at %0t: run did not finish", $time);
    end_of_test();
  end
  // ==========
  // Scenarios
  initial begin
    int n;
    int k;
    failures = 0;
    compares = 0;
    seed = 32'h0b67;
    loads = 0;
    rstn = 1'b0;
    direct_wiring = 1'b0;
    mod_bit = 1'b0;
    tx_word = 16'h0000;
    tx_valid = 1'b0;
    seen_pass = 1'b0;
    pass_exp = 16'h0000;
    do_reset(1'b0, 16'h0000);
    chkn(32'(mode), 32'(csp_pkg::CSP_PROGRAM));
    chkn(32'(cascade_count), 0);
    wait_sp(n);
    wait_sp(n);
    chkn(n, 2048);
    // Every rate; third interval is clean
    for (int s = 0; s < 4; s++) begin
      send(cw(1'b0, 3'h0, 4'h1, 8'(s)));
      repeat (3) wait_sp(n);
      chkn(n, 256 << s);
    end
    send(cw(1'b0, 3'h0, 4'h2, 8'h01));
    repeat (3) wait_sp(n);
    chkn(n, 4096);
    // Word for a later unit passes on
    w[0] = cw(1'b0, 3'h3, 4'h0, 8'($random(seed)));
    pass_exp = {w[0][15], 3'h2, w[0][11:0]};
    seen_pass = 1'b0;
    send(w[0]);
    repeat (3) wait_sp(n);
    chkn(32'(seen_pass), 1);
    // Data mode, random cascade length
    k = $random(seed) & 7;
    send(cw(1'b0, 3'h0, 4'h0, {3'h0, 3'(k), 2'b01}));
    repeat (3) wait_sp(n);
    chkn(32'(mode), 32'(csp_pkg::CSP_DATA));
    chkn(32'(cascade_count), k);
    loads = 0;
    for (int i = 0; i <= k; i++) begin
      w[i] = 16'($random(seed));
      send(w[i]);
    end
    repeat (2) wait_sp(n);
    chkn(loads, 1);
    chk16(last_dac, w[k]);
    send(cw(1'b0, 3'h0, 4'h0, 8'h03));
    repeat (2) wait_sp(n);
    chkn(32'(mode), 32'(csp_pkg::CSP_DATA));
    // Mixed mode data, then a control word
    do_reset(1'b0, 16'h0000);
    send(cw(1'b0, 3'h0, 4'h0, 8'h03));
    repeat (3) wait_sp(n);
    chkn(32'(mode), 32'(csp_pkg::CSP_MIXED));
    mixed_chk = 1'b1;
    loads = 0;
    w[0] = {1'b0, 15'($random(seed))};
    send(w[0]);
    repeat (2) wait_sp(n);
    chkn(loads, 1);
    chk16(last_dac, {w[0][14:0], 1'b0});
    send(cw(1'b1, 3'h0, 4'h0, 8'h0b));
    repeat (2) wait_sp(n);
    chkn(32'(cascade_count), 2);
    // Direct wiring with a preloaded word
    do_reset(1'b1, cw(1'b0, 3'h0, 4'h0, 8'h05));
    repeat (3) wait_sp(n);
    chkn(32'(mode), 32'(csp_pkg::CSP_DATA));
    chkn(32'(cascade_count), 1);
    end_of_test();
  end
endmodule
`default_nettype wire
